// file: src/pei_pkg.sv
// Constants for the T1 transmit payload error inserter.
// Assumes one host port and one transmit bit stream on the same clock.
// Overview of operation
// R01 - Insert payload errors only in T1 mode; never alter bits otherwise.
// R02 - Errors go into payload, across all channels or only selected channels.
// R03 - Count payload bits and invert the Nth bit of each interval.
// R04 - Framing bits are not counted and are never inverted.
// R05 - A new error rate takes effect only at the next frame boundary.
// R06 - Rate code 0 inserts nothing; code 1 is 1 in 16, doubling up.
// R07 - Rate code zero gives no errors even with continuous mode set.
// R08 - Continuous bit set with nonzero rate ignores count, inserts forever.
// R09 - Continuous bit clear inserts only the loaded number of errors.
// R10 - Load strobe rising edge moves count registers into logic next cycle.
// R11 - Host writes counts before raising strobe, then 0 and 1 again later.
// R12 - Error count is 10 bits: low byte, then bits 8 and 9.
// R13 - Loaded zero means no errors; loaded n means exactly n errors.
// R14 - Remaining errors readable anytime as low byte and two high bits.
// R15 - Host writes zero to unused control bits 5 and 6.
// R16 - Counted mode decrements per inserted error, stops at zero.
// R17 - Without channel selection all channels count; only eligible bits count.
package pei_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam int          RATE_W         = 4;
    localparam int          CNT_W          = 10;
    localparam int          INT_W          = 18;
    localparam int          RATE_SHIFT     = 3;
    localparam logic [7:0]  ADDR_RATE_CTRL = 8'hEB;
    localparam logic [7:0]  ADDR_CNT_LO    = 8'hEC;
    localparam logic [7:0]  ADDR_CNT_HI    = 8'hED;
    localparam logic [7:0]  ADDR_LEFT_LO   = 8'hEE;
    localparam logic [7:0]  ADDR_LEFT_HI   = 8'hEF;
    localparam int          CTRL_CONT_BIT  = 4;
    localparam int          CTRL_LOAD_BIT  = 7;
    localparam int          HI_BITS        = 2;
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [3:0]  RATE_NONE      = 4'h0;
endpackage

// file: src/pei_rate_if.sv
// Link between the error inserter control and its rate interval counter.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface pei_rate_if;
    logic                       step;
    logic                       frame_start;
    logic [pei_pkg::RATE_W-1:0] rate_req;
    logic                       hit;
    modport ctl (output step, output frame_start, output rate_req,
                 input hit);
    modport cnt (input step, input frame_start, input rate_req,
                 output hit);
endinterface

// file: src/pei_rate_counter.sv
// Interval counter that marks the last bit of each error interval.
// Assumes step pulses once per eligible payload bit.
`timescale 1ns/10ps
module pei_rate_counter (
    // Clock and control
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_ce,
    // Link to control
    pei_rate_if.cnt   rif
);
    // =========================================================
    // Active rate and interval count
    logic [pei_pkg::RATE_W-1:0] rate_r, rate_nxt;
    logic [pei_pkg::INT_W-1:0]  cnt_r, cnt_nxt;
    logic [pei_pkg::INT_W-1:0]  last;

    always_comb begin
        rate_nxt = rate_r;
        cnt_nxt  = cnt_r;
        // The terminal value is N minus one with N = 2 to the rate plus 3.
        last = pei_pkg::INT_W'((pei_pkg::INT_W+1)'(1)
               << (rate_r + pei_pkg::RATE_SHIFT)) - pei_pkg::INT_W'(1); // R06
        rif.hit = rif.step && (rate_r != pei_pkg::RATE_NONE)
                  && (cnt_r == last); // R03 R07
        if (rif.frame_start && rif.rate_req != rate_r) begin
            // Restart only when the rate changes: a long interval must span
            // frames, else slow rates could never reach their last bit.
            rate_nxt = rif.rate_req; // R05
            cnt_nxt  = '0;
        end else if (rif.step && rate_r != pei_pkg::RATE_NONE) begin
            cnt_nxt = rif.hit ? '0 : cnt_r + pei_pkg::INT_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rate_r <= '0;
            cnt_r  <= '0;
        end else if (i_ce) begin
            rate_r <= rate_nxt;
            cnt_r  <= cnt_nxt;
        end
    end
endmodule

// file: src/pei_top.sv
// T1 transmit payload error inserter with its host registers.
// Assumes host port and bit stream run on i_clk, one bit per i_bit_valid.
// Assumes the formatter flags framing bits and frame starts on the stream.
`timescale 1ns/10ps
module pei_top (
    // Clock, reset, enable
    input  wire logic                        i_clk,
    input  wire logic                        i_srst,
    input  wire logic                        i_ce,
    // Host register port
    input  wire logic [pei_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic                        i_wr,
    input  wire logic [pei_pkg::DATA_W-1:0]  i_wdata,
    output logic      [pei_pkg::DATA_W-1:0]  o_rdata,
    // Line mode and channel selection
    input  wire logic                        i_t1_mode,
    input  wire logic                        i_chan_sel_en,
    input  wire logic                        i_chan_sel,
    // Transmit bit stream in
    input  wire logic                        i_bit_valid,
    input  wire logic                        i_bit_data,
    input  wire logic                        i_fbit,
    input  wire logic                        i_frame_start,
    // Transmit bit stream out
    output logic                             o_bit_valid,
    output logic                             o_bit_data,
    output logic                             o_err_inserted
);
    // =========================================================
    // Host register state
    logic [pei_pkg::DATA_W-1:0]  ctrl_r, ctrl_nxt;
    logic [pei_pkg::DATA_W-1:0]  cnt_lo_r, cnt_lo_nxt;
    logic [pei_pkg::HI_BITS-1:0] cnt_hi_r, cnt_hi_nxt;
    logic [pei_pkg::CNT_W-1:0]   left_r, left_nxt;
    logic                        load_prev_r, load_prev_nxt;
    logic [pei_pkg::DATA_W-1:0]  rdata_r, rdata_nxt;

    // Write decode and read-back helpers
    logic                        wr_ctrl;
    logic                        wr_cnt_lo;
    logic                        wr_cnt_hi;
    logic                        load_edge;
    logic [pei_pkg::HI_BITS-1:0] left_hi;

    // Bit path state
    logic                        vld_r, vld_nxt;
    logic                        dat_r, dat_nxt;
    logic                        err_r, err_nxt;
    logic                        eligible;
    logic                        insert;
    logic                        cont;

    // =========================================================
    // Rate interval counter
    // The counter keeps its own copy of the rate, so a write to the
    // rate field only reaches the interval logic at a frame boundary.
    pei_rate_if rif ();

    pei_rate_counter u_rate (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .rif    (rif)
    );

    // =========================================================
    // Eligibility and insertion decision
    always_comb begin
        // A framing bit or a deselected channel neither counts nor flips.
        eligible = i_bit_valid && i_t1_mode && !i_fbit // R01 R04
                   && (!i_chan_sel_en || i_chan_sel); // R02 R17
        cont     = ctrl_r[pei_pkg::CTRL_CONT_BIT];
        insert   = rif.hit && (cont || left_r != '0); // R08 R09 R13
    end

    // =========================================================
    // Link to the rate counter
    always_comb begin
        rif.step        = eligible;
        rif.frame_start = i_frame_start; // R05
        rif.rate_req    = ctrl_r[pei_pkg::RATE_W-1:0];
    end

    // =========================================================
    // Bit path
    always_comb begin
        vld_nxt = i_bit_valid;
        dat_nxt = i_bit_data ^ insert; // R03
        err_nxt = insert;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            vld_r <= 1'b0;
            dat_r <= 1'b0;
            err_r <= 1'b0;
        end else if (i_ce) begin
            vld_r <= vld_nxt;
            dat_r <= dat_nxt;
            err_r <= err_nxt;
        end
    end

    // =========================================================
    // Write decode
    // Writes to the read-only remaining-count addresses fall through.
    // Only one register can be written in a cycle.
    always_comb begin
        wr_ctrl   = 1'b0;
        wr_cnt_lo = 1'b0;
        wr_cnt_hi = 1'b0;
        if (i_wr && i_addr == pei_pkg::ADDR_RATE_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (i_wr && i_addr == pei_pkg::ADDR_CNT_LO) begin
            wr_cnt_lo = 1'b1;
        end else if (i_wr && i_addr == pei_pkg::ADDR_CNT_HI) begin
            wr_cnt_hi = 1'b1;
        end
    end

    // =========================================================
    // Rate control register
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            // Bits 5 and 6 are stored as written; the host keeps them 0.
            ctrl_nxt = i_wdata; // R15
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_r <= pei_pkg::RST_BYTE;
        end else if (i_ce) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // =========================================================
    // Requested error count
    always_comb begin
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        if (wr_cnt_lo) begin
            cnt_lo_nxt = i_wdata; // R12
        end
        if (wr_cnt_hi) begin
            // Only the two top count bits exist; the rest read as zero.
            cnt_hi_nxt = i_wdata[pei_pkg::HI_BITS-1:0]; // R12
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_lo_r <= pei_pkg::RST_BYTE;
            cnt_hi_r <= '0;
        end else if (i_ce) begin
            cnt_lo_r <= cnt_lo_nxt;
            cnt_hi_r <= cnt_hi_nxt;
        end
    end

    // =========================================================
    // Load strobe edge and remaining-error count
    always_comb begin
        load_prev_nxt = ctrl_r[pei_pkg::CTRL_LOAD_BIT];
        load_edge     = ctrl_r[pei_pkg::CTRL_LOAD_BIT] && !load_prev_r; // R10
        left_nxt      = left_r;
        // A strobe edge outranks a decrement in the same cycle, so a
        // reload is never lost to an error that lands on the same bit.
        if (load_edge) begin
            left_nxt = {cnt_hi_r, cnt_lo_r}; // R10 R13
        end else if (insert && !cont) begin
            left_nxt = left_r - pei_pkg::CNT_W'(1); // R16
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            load_prev_r <= 1'b0;
            left_r      <= '0;
        end else if (i_ce) begin
            load_prev_r <= load_prev_nxt;
            left_r      <= left_nxt;
        end
    end

    // =========================================================
    // Read-back
    // Unmapped addresses read zero, so a stray read is harmless.
    always_comb begin
        left_hi = left_r[pei_pkg::CNT_W-1:pei_pkg::DATA_W];
        if (i_addr == pei_pkg::ADDR_RATE_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (i_addr == pei_pkg::ADDR_CNT_LO) begin
            rdata_nxt = cnt_lo_r;
        end else if (i_addr == pei_pkg::ADDR_CNT_HI) begin
            rdata_nxt = pei_pkg::DATA_W'(cnt_hi_r); // R12
        end else if (i_addr == pei_pkg::ADDR_LEFT_LO) begin
            rdata_nxt = left_r[pei_pkg::DATA_W-1:0]; // R14
        end else if (i_addr == pei_pkg::ADDR_LEFT_HI) begin
            rdata_nxt = pei_pkg::DATA_W'(left_hi); // R14
        end else begin
            rdata_nxt = pei_pkg::RST_BYTE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_r <= pei_pkg::RST_BYTE;
        end else if (i_ce) begin
            rdata_r <= rdata_nxt;
        end
    end

    // =========================================================
    // Outputs
    // Every output is a flop, so the line side never sees a glitch.
    assign o_rdata        = rdata_r;
    assign o_bit_valid    = vld_r;
    assign o_bit_data     = dat_r;
    assign o_err_inserted = err_r;
endmodule

// file: tb/pei_fmt_model.sv
// Transmit formatter stand-in: 193-bit frames, F-bit at index 0.
// Assumes i_slow high halves the bit rate.
`timescale 1ns/10ps
module pei_fmt_model (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_slow,
    output logic      o_valid,
    output logic      o_data,
    output logic      o_fbit,
    output logic      o_fs,
    output logic      o_sel
);
    // ================================================================
    // Idle data is high, payload low, so stale data never looks valid.
    logic [7:0] idx_r = 8'h00;
    logic       gap_r = 1'b0;
    always @(posedge i_clk) begin
        gap_r <= i_slow & ~gap_r;
        if (i_srst)
            idx_r <= 8'h00;
        else if (!gap_r)
            idx_r <= (idx_r == 8'hC0) ? 8'h00 : idx_r + 8'h01;
    end
    assign o_valid = ~i_srst & ~gap_r;
    assign o_fbit  = (idx_r == 8'h00);
    assign o_fs    = o_valid & o_fbit;
    assign o_data  = ~o_valid;
    assign o_sel   = idx_r[3];
endmodule

// file: tb/pei_top_asserts.sv
// Port-level properties of the payload error inserter.
// Assumes i_ce is held high, so every edge is an enabled one.
`timescale 1ns/10ps
module pei_asserts (
    input wire logic       i_clk, i_srst, i_ce, i_wr, i_t1_mode,
    input wire logic       i_chan_sel_en, i_chan_sel, i_bit_valid,
    input wire logic       i_bit_data, i_fbit, i_frame_start,
    input wire logic       o_bit_valid, o_bit_data, o_err_inserted,
    input wire logic [7:0] i_addr, i_wdata, o_rdata
);
    // ================================================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_quiet; !o_err_inserted [*8]; endsequence
    property p_fbit; i_bit_valid && i_fbit |=> !o_err_inserted; endproperty
    property p_mode; !i_t1_mode |=> !o_err_inserted; endproperty
    property p_desel;
        i_chan_sel_en && !i_chan_sel |=> !o_err_inserted;
    endproperty
    property p_pass; $past(i_bit_valid) |-> o_bit_valid &&
        ((o_bit_data != $past(i_bit_data)) == o_err_inserted); endproperty
    property p_errv; o_err_inserted |-> $past(i_bit_valid); endproperty
    property p_space; $rose(o_err_inserted) |=> s_quiet; endproperty
    property p_hi; i_addr == 8'hED |=> o_rdata[7:2] == 6'h00; endproperty
    property p_left; i_addr == 8'hEF |=> o_rdata[7:2] == 6'h00; endproperty
    a_fbit: assert property (p_fbit) else $error("F-bit hit");
    a_mode: assert property (p_mode) else $error("hit off T1");
    a_desel: assert property (p_desel) else $error("bad chan");
    a_pass: assert property (p_pass) else $error("bad data");
    a_errv: assert property (p_errv) else $error("no bit");
    a_space: assert property (p_space) else $error("too close");
    a_hi: assert property (p_hi) else $error("count high bits");
    a_left: assert property (p_left) else $error("left high bits");
endmodule
bind pei_top pei_asserts pei_asserts_inst (.*);

// file: tb/test_t1_payload_error_inserter.sv
// Self-checking bench for the payload error inserter.
// Assumes pei_fmt_model feeds the stream; host port is driven here.
`timescale 1ns/10ps
module test_t1_payload_error_inserter;
    // ================================================================
    logic       i_clk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_wr = 1'b0;
    logic       i_t1_mode = 1'b1, i_chan_sel_en = 1'b0, slow = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [7:0] cnt_r = 8'h00, last_r = 8'h00;
    logic       i_chan_sel, i_bit_valid, i_bit_data, i_fbit, i_frame_start;
    logic       o_bit_valid, o_bit_data, o_err_inserted, fs_d = 1'b0;
    int         failures = 0, checked = 0, exp_old = 0;
    `define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
        $display("[ERR] %0t got %h exp %h", $time, a, e); end end
    pei_top pei_top_inst (.*);
    pei_fmt_model pei_fmt_model_inst (.i_clk(i_clk), .i_srst(i_srst),
        .i_slow(slow), .o_valid(i_bit_valid), .o_data(i_bit_data),
        .o_fbit(i_fbit), .o_fs(i_frame_start), .o_sel(i_chan_sel));
    // Errors per frame, counted on the output side one cycle late.
    always @(posedge i_clk) begin
        fs_d <= i_frame_start;
        cnt_r <= (fs_d ? 8'h00 : cnt_r) + {7'h00, o_err_inserted};
        if (fs_d)
            last_r <= cnt_r;
    end
    initial forever #5 i_clk = ~i_clk;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        @(posedge i_clk);
        @(negedge i_clk);
        `CHK(o_rdata, e)
    endtask
    task automatic frame(input int n);
        repeat (n) @(posedge fs_d);
        @(posedge i_clk);
        @(negedge i_clk);
    endtask
    task automatic finish_test;
        $display("TB: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int a = 8'hEA; a < 8'hF0; a++) rdc(8'(a), 8'h00);
        wr(8'hEB, 8'h10);
        frame(2);
        `CHK(last_r, 8'h00)
        for (int r = 1; r < 16; r++) begin
            wr(8'hEB, 8'h10 | 8'(r));
            frame(1);
            // Old rate in its second frame: hits in 384 bits less 192.
            exp_old = (384 >> (r + 2)) - (192 >> (r + 2));
            `CHK(last_r, (r == 1) ? 8'h00 : 8'(exp_old))
            frame(1);
            `CHK(last_r, 8'(192 >> (r + 3)))
        end
        wr(8'hEB, 8'h01);
        frame(1);
        wr(8'hEC, 8'h03);
        wr(8'hED, 8'h00);
        wr(8'hEB, 8'h81);
        rdc(8'hEE, 8'h03);
        frame(1);
        `CHK(last_r, 8'h03)
        rdc(8'hEE, 8'h00);
        @(posedge i_clk) i_t1_mode <= 1'b0;
        wr(8'hEC, 8'hFF);
        wr(8'hED, 8'hFF);
        wr(8'hEB, 8'h01);
        wr(8'hEB, 8'h81);
        frame(2);
        `CHK(last_r, 8'h00)
        rdc(8'hED, 8'h03);
        rdc(8'hEE, 8'hFF);
        rdc(8'hEF, 8'h03);
        wr(8'hEC, 8'h00);
        wr(8'hED, 8'h00);
        wr(8'hEB, 8'h01);
        wr(8'hEB, 8'h81);
        @(posedge i_clk) i_t1_mode <= 1'b1;
        frame(2);
        `CHK(last_r, 8'h00)
        @(posedge i_clk) i_chan_sel_en <= 1'b1;
        slow <= 1'b1;
        wr(8'hEB, 8'h11);
        frame(2);
        `CHK(last_r, 8'h06)
        finish_test();
    end
endmodule
